// ---- pkg/mtc_pkg.sv ----
// Package for the Manchester and three-of-six line-code coder.
package mtc_pkg;

  localparam logic [7:0] MTC_ADDR_CTRL = 8'hc5;
  localparam logic [7:0] MTC_ADDR_LOW = 8'hc2;
  localparam logic [7:0] MTC_ADDR_MID = 8'hc3;
  localparam logic [7:0] MTC_ADDR_HIGH = 8'hc4;

  localparam int MTC_BIT_READY = 7;
  localparam int MTC_BIT_ERROR = 6;
  localparam int MTC_BIT_ENC = 5;
  localparam int MTC_BIT_DEC = 4;
  localparam int MTC_BIT_DMA = 2;
  localparam int MTC_BIT_ENDIAN = 1;
  localparam int MTC_BIT_MODE = 0;

  localparam logic [7:0] MTC_CTRL_RESET = 8'h00;
  localparam logic [7:0] MTC_DATA_RESET = 8'h00;
  localparam logic [7:0] MTC_ALL_ONES = 8'hff;
  localparam logic [7:0] MTC_UNMAPPED = 8'h00;

  localparam logic [1:0] MTC_PAIR_ONE = 2'b01;
  localparam logic [1:0] MTC_PAIR_ZERO = 2'b10;

  localparam logic [5:0] MTC_SYM [16] = '{
    6'h16, 6'h0d, 6'h0e, 6'h0b, 6'h1c, 6'h19, 6'h1a, 6'h13,
    6'h2c, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29
  };

  typedef struct packed {
    logic ready;
    logic error;
    logic enc_start;
    logic dec_start;
    logic dma_mode;
    logic big_endian;
    logic code_sel;
  } mtc_ctrl_type;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
  } mtc_data_type;

  typedef enum logic [0:0] {MTC_IDLE, MTC_LAUNCH} mtc_state_type;

endpackage

// ---- verilog/mtc_codec.sv ----
// Register-driven Manchester and three-of-six encoder and decoder.
`timescale 1ns/1ns
module mtc_codec
  import mtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic decode_err_irq,
  output logic dma_mode,
  output logic big_endian
);

  ////////////////////////////////////////////////////////////////////////////
  // Code functions.

  function automatic logic [7:0] man_enc(input logic [3:0] nib);
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < 4; i++) begin
      res[2*i +: 2] = nib[i] ? MTC_PAIR_ONE : MTC_PAIR_ZERO;
    end
    return res;
  endfunction

  // Returns a valid flag above the nibble.
  function automatic logic [4:0] man_dec(input logic [7:0] code);
    logic [4:0] res;
    res = 5'h10;
    for (int i = 0; i < 4; i++) begin
      res[i] = (code[2*i +: 2] == MTC_PAIR_ONE);
      if (code[2*i +: 2] != MTC_PAIR_ONE && code[2*i +: 2] != MTC_PAIR_ZERO)
        res[4] = 1'b0;
    end
    return res;
  endfunction

  function automatic logic [4:0] sym_dec(input logic [5:0] sym);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (MTC_SYM[i] == sym) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  mtc_ctrl_type ctrl_ff;
  mtc_data_type data_ff;
  mtc_data_type nxt_data;
  mtc_state_type state_ff;
  logic [7:0] rdata_ff;
  logic irq_ff;
  logic nxt_err;
  logic launch;
  logic wr_ctrl;
  logic [4:0] md_hi;
  logic [4:0] md_lo;
  logic [4:0] sd [4];

  assign wr_ctrl = bus_wr && bus_addr == MTC_ADDR_CTRL;
  assign launch = ctrl_ff.enc_start || ctrl_ff.dec_start;

  // Four symbols of a 24-bit word, least significant first.
  generate
    for (genvar g = 0; g < 4; g++) begin : g_sym
      assign sd[g] = sym_dec(data_ff[6*g +: 6]);
    end
  endgenerate

  assign md_hi = man_dec(data_ff.mid);
  assign md_lo = man_dec(data_ff.low);

  ////////////////////////////////////////////////////////////////////////////
  // Result of the launched operation.

  always_comb begin
    nxt_data = data_ff;
    nxt_err = 1'b0;
    if (ctrl_ff.enc_start && !ctrl_ff.code_sel) begin
      nxt_data.mid = man_enc(data_ff.low[7:4]);
      nxt_data.low = man_enc(data_ff.low[3:0]);
    end else if (ctrl_ff.enc_start) begin
      nxt_data = {MTC_SYM[data_ff.mid[7:4]], MTC_SYM[data_ff.mid[3:0]],
                  MTC_SYM[data_ff.low[7:4]], MTC_SYM[data_ff.low[3:0]]};
    end else if (ctrl_ff.dec_start && !ctrl_ff.code_sel) begin
      nxt_err = !(md_hi[4] && md_lo[4]);
      nxt_data.low = nxt_err ? MTC_ALL_ONES : {md_hi[3:0], md_lo[3:0]};
    end else if (ctrl_ff.dec_start) begin
      nxt_err = !(sd[3][4] && sd[2][4] && sd[1][4] && sd[0][4]);
      nxt_data.mid = {sd[3][3:0], sd[2][3:0]};
      nxt_data.low = {sd[1][3:0], sd[0][3:0]};
      if (nxt_err) begin
        nxt_data.mid = MTC_ALL_ONES;
        nxt_data.low = MTC_ALL_ONES;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data registers; the result of a launch wins over a bus write.

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      data_ff <= {3{MTC_DATA_RESET}};
    end else if (launch) begin
      data_ff <= nxt_data;
    end else if (bus_wr) begin
      if (bus_addr == MTC_ADDR_LOW) data_ff.low <= bus_wdata;
      if (bus_addr == MTC_ADDR_MID) data_ff.mid <= bus_wdata;
      if (bus_addr == MTC_ADDR_HIGH) data_ff.high <= bus_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; hardware setting ready or error wins over a clear.

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_ff <= mtc_ctrl_type'(7'(MTC_CTRL_RESET));
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.ready <= ctrl_ff.ready && bus_wdata[MTC_BIT_READY];
        ctrl_ff.error <= ctrl_ff.error && bus_wdata[MTC_BIT_ERROR];
        ctrl_ff.dma_mode <= bus_wdata[MTC_BIT_DMA];
        ctrl_ff.big_endian <= bus_wdata[MTC_BIT_ENDIAN];
        ctrl_ff.code_sel <= bus_wdata[MTC_BIT_MODE];
      end
      ctrl_ff.enc_start <= wr_ctrl && bus_wdata[MTC_BIT_ENC];
      ctrl_ff.dec_start <= wr_ctrl && bus_wdata[MTC_BIT_DEC] &&
                           !bus_wdata[MTC_BIT_ENC];
      if (launch) begin
        ctrl_ff.ready <= 1'b1;
      end
      if (launch && nxt_err) begin
        ctrl_ff.error <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_ff <= MTC_IDLE;
    end else begin
      unique case (state_ff)
        MTC_IDLE: state_ff <= launch ? MTC_LAUNCH : MTC_IDLE;
        MTC_LAUNCH: state_ff <= launch ? MTC_LAUNCH : MTC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= launch && nxt_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port.

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_ff <= MTC_UNMAPPED;
    end else if (bus_rd) begin
      unique case (bus_addr)
        MTC_ADDR_CTRL: rdata_ff <= {ctrl_ff[6:3], 1'b0, ctrl_ff[2:0]};
        MTC_ADDR_LOW: rdata_ff <= data_ff.low;
        MTC_ADDR_MID: rdata_ff <= data_ff.mid;
        MTC_ADDR_HIGH: rdata_ff <= data_ff.high;
        default: rdata_ff <= MTC_UNMAPPED;
      endcase
    end else begin
      rdata_ff <= MTC_UNMAPPED;
    end
  end

  assign bus_rdata = rdata_ff;
  assign decode_err_irq = irq_ff;
  assign dma_mode = ctrl_ff.dma_mode;
  assign big_endian = ctrl_ff.big_endian;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_start_clears;
    @(posedge clk_sys) disable iff (!rst_b)
    launch |=> !launch || $past(wr_ctrl);
  endproperty
  a_start_clears: assert property (p_start_clears)
    else $error("start bit did not clear");

  property p_ready_sets;
    @(posedge clk_sys) disable iff (!rst_b)
    launch |=> ctrl_ff.ready && state_ff == MTC_LAUNCH;
  endproperty
  a_ready_sets: assert property (p_ready_sets)
    else $error("ready not set after launch");

  property p_ready_holds;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.ready && !(wr_ctrl && !bus_wdata[MTC_BIT_READY])
      |=> ctrl_ff.ready;
  endproperty
  a_ready_holds: assert property (p_ready_holds)
    else $error("ready dropped by hardware");

  property p_combined;
    @(posedge clk_sys) disable iff (!rst_b)
    wr_ctrl && bus_wdata[MTC_BIT_ENC] && !bus_wdata[MTC_BIT_READY]
      |=> ##1 ctrl_ff.ready;
  endproperty
  a_combined: assert property (p_combined)
    else $error("combined clear and start failed");

  property p_man_enc;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.enc_start && !ctrl_ff.code_sel
      |=> data_ff.mid == man_enc($past(data_ff.low[7:4])) &&
          data_ff.high == $past(data_ff.high);
  endproperty
  a_man_enc: assert property (p_man_enc)
    else $error("Manchester encode result wrong");

  property p_man_err;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.dec_start && !ctrl_ff.code_sel && !md_lo[4]
      |=> ctrl_ff.error && data_ff.low == MTC_ALL_ONES;
  endproperty
  a_man_err: assert property (p_man_err)
    else $error("Manchester decode error not flagged");

  property p_sym_enc;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.enc_start && ctrl_ff.code_sel
      |=> data_ff.high[7:2] == MTC_SYM[$past(data_ff.mid[7:4])];
  endproperty
  a_sym_enc: assert property (p_sym_enc)
    else $error("three-of-six symbol order wrong");

  property p_sym_err;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.dec_start && ctrl_ff.code_sel && !sd[0][4]
      |=> ctrl_ff.error && data_ff.mid == MTC_ALL_ONES;
  endproperty
  a_sym_err: assert property (p_sym_err)
    else $error("three-of-six decode error not flagged");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_b)
    decode_err_irq |-> ctrl_ff.error && $past(ctrl_ff.dec_start);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without decode error");

  property p_man_zero;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.enc_start && !ctrl_ff.code_sel && data_ff.low[3:0] == 4'h0
      |=> data_ff.low == 8'haa;
  endproperty
  a_man_zero: assert property (p_man_zero)
    else $error("Manchester code of a zero nibble wrong");

  property p_man_dec_keep;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.dec_start && !ctrl_ff.code_sel
      |=> data_ff.high == $past(data_ff.high) &&
          data_ff.mid == $past(data_ff.mid);
  endproperty
  a_man_dec_keep: assert property (p_man_dec_keep)
    else $error("Manchester decode touched high or mid");

  property p_sym_low;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.enc_start && ctrl_ff.code_sel
      |=> data_ff.low[5:0] == MTC_SYM[$past(data_ff.low[3:0])];
  endproperty
  a_sym_low: assert property (p_sym_low)
    else $error("three-of-six low symbol wrong");

  property p_sym_span;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.enc_start && ctrl_ff.code_sel
      |=> data_ff.high[1:0] == MTC_SYM[$past(data_ff.mid[3:0])][5:4];
  endproperty
  a_sym_span: assert property (p_sym_span)
    else $error("three-of-six symbol not packed across bytes");

  property p_sym_dec_keep;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.dec_start && ctrl_ff.code_sel
      |=> data_ff.high == $past(data_ff.high);
  endproperty
  a_sym_dec_keep: assert property (p_sym_dec_keep)
    else $error("three-of-six decode touched high");

  property p_sym_ok;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.dec_start && ctrl_ff.code_sel && !wr_ctrl &&
      sd[3][4] && sd[2][4] && sd[1][4] && sd[0][4]
      |=> ctrl_ff.error == $past(ctrl_ff.error);
  endproperty
  a_sym_ok: assert property (p_sym_ok)
    else $error("valid symbols changed the error flag");

  property p_bit3;
    @(posedge clk_sys) disable iff (!rst_b)
    bus_rd && bus_addr == MTC_ADDR_CTRL |=> bus_rdata[3] == 1'b0;
  endproperty
  a_bit3: assert property (p_bit3)
    else $error("control bit 3 read as one");

  property p_rd_idle;
    @(posedge clk_sys) disable iff (!rst_b)
    !bus_rd |=> bus_rdata == MTC_UNMAPPED;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside the read cycle");

  property p_sym_err_low;
    @(posedge clk_sys) disable iff (!rst_b)
    ctrl_ff.dec_start && ctrl_ff.code_sel && !sd[3][4]
      |=> ctrl_ff.error && data_ff.low == MTC_ALL_ONES;
  endproperty
  a_sym_err_low: assert property (p_sym_err_low)
    else $error("three-of-six error output not all ones");

  property p_no_start;
    @(posedge clk_sys) disable iff (!rst_b)
    !wr_ctrl |=> !launch;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("start bit stood without a control write");

endmodule

// ---- tb/mtc_codec_tb.sv ----
// Self-checking testbench for the Manchester and three-of-six coder.
`timescale 1ns/1ns
module mtc_codec_tb;
  import mtc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic decode_err_irq;
  logic dma_mode;
  logic big_endian;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int checks_done = 0;
  int irq_seen = 0;
  int seed = 32'h2c5e1527;
  logic [31:0] r;
  logic [7:0] b;
  logic [15:0] v;
  logic [23:0] s;
  logic [5:0] sym [16] = '{6'h16, 6'h0d, 6'h0e, 6'h0b, 6'h1c, 6'h19,
    6'h1a, 6'h13, 6'h2c, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};

  always #4 clk_sys = ~clk_sys;

  mtc_codec uut (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .decode_err_irq(decode_err_irq),
    .dma_mode(dma_mode),
    .big_endian(big_endian)
  );

  ////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function logic [7:0] menc(input logic [3:0] n);
    menc = 8'h00;
    for (int i = 3; i >= 0; i--) begin
      menc = {menc[5:0], n[i] ? 2'b01 : 2'b10};
    end
  endfunction

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    bus_rd <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Read data are valid only in the cycle after the read strobe.
  always @(posedge clk_sys) begin
    if (rd_q) begin
      check(bus_rdata, exp_q.pop_front());
    end
    if (decode_err_irq === 1'b1) begin
      irq_seen++;
    end
    rd_q <= bus_rd;
  end

  initial begin
    #100000;
    miscompares++;
    test_done;
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(MTC_ADDR_CTRL, 8'h00);
    rd(MTC_ADDR_HIGH, 8'h00);
    rd(8'h77, 8'h00);
    wr(MTC_ADDR_CTRL, 8'hce);
    rd(MTC_ADDR_CTRL, 8'h06);
    check({6'h00, dma_mode, big_endian}, 8'h03);
    wr(MTC_ADDR_CTRL, 8'h00);
    wr(MTC_ADDR_HIGH, 8'h5a);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      b = {i[3:0], r[3:0]};
      wr(MTC_ADDR_LOW, b);
      rd(MTC_ADDR_LOW, b);
      wr(MTC_ADDR_CTRL, 8'h20);
      rd(MTC_ADDR_CTRL, 8'h80);
      rd(MTC_ADDR_MID, menc(b[7:4]));
      rd(MTC_ADDR_LOW, menc(b[3:0]));
      wr(MTC_ADDR_CTRL, 8'h10);
      repeat (10) @(posedge clk_sys);
      rd(MTC_ADDR_CTRL, 8'h80);
      rd(MTC_ADDR_LOW, b);
    end
    rd(MTC_ADDR_HIGH, 8'h5a);
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      v = {i[3:0], r[11:0]};
      wr(MTC_ADDR_MID, v[15:8]);
      wr(MTC_ADDR_LOW, v[7:0]);
      wr(MTC_ADDR_CTRL, 8'h21);
      rd(MTC_ADDR_CTRL, 8'h81);
      s = {sym[v[15:12]], sym[v[11:8]], sym[v[7:4]], sym[v[3:0]]};
      rd(MTC_ADDR_HIGH, s[23:16]);
      rd(MTC_ADDR_MID, s[15:8]);
      rd(MTC_ADDR_LOW, s[7:0]);
      wr(MTC_ADDR_CTRL, 8'h11);
      rd(MTC_ADDR_CTRL, 8'h81);
      rd(MTC_ADDR_MID, v[15:8]);
      rd(MTC_ADDR_LOW, v[7:0]);
    end
    wr(MTC_ADDR_LOW, 8'h00);
    wr(MTC_ADDR_CTRL, 8'h10);
    rd(MTC_ADDR_CTRL, 8'hc0);
    rd(MTC_ADDR_LOW, 8'hff);
    wr(MTC_ADDR_CTRL, 8'h00);
    rd(MTC_ADDR_CTRL, 8'h00);
    wr(MTC_ADDR_HIGH, 8'h00);
    wr(MTC_ADDR_CTRL, 8'h11);
    rd(MTC_ADDR_CTRL, 8'hc1);
    rd(MTC_ADDR_MID, 8'hff);
    rd(MTC_ADDR_LOW, 8'hff);
    repeat (3) @(posedge clk_sys);
    check(8'(irq_seen), 8'h02);
    test_done;
  end
endmodule
